// ===== logic/pstcs_host.sv
// Baseband controller end: preamble shaping and select-pin sequencing
//
// Behaviour
// [RULE_01] Send at least 50 us alternating preamble
// [RULE_02] Slice point after 20 us pattern
// [RULE_03] Drive select low after 20 us
// [RULE_04] Mode 4: select picks 300/6 us
// [RULE_05] Mode 5: select picks 300/3 us
// [RULE_06] Short constant: 25 us preamble, 10 us
// [RULE_07] Recovered clock valid 100 us after lock
// [RULE_08] Select low before acquisition window ends
// [RULE_09] Full-preamble frame every three minutes
// [RULE_10] Optional 1100 pattern after settling
// [RULE_11] Skip bit drops VCO recalibration
// [RULE_12] Calibrate on receive entry before slicing
// [RULE_13] Preamble timed in whole own clock cycles
module pstcs_host #(
   parameter int SEC_CYC = 100000000
) (
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RESETN_I,
   // Software port
   input wire logic [3:0] ADDR_I,
   input wire logic [15:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [15:0] RDATA_O,
   // Link
   pstcs_if.host LNK
);
   localparam int DEPTH = 2;

   typedef struct packed {
      pstcs_pkg::pstcs_hst_e st;
      logic [4:0] ctrl;
      logic [pstcs_pkg::CNT_W-1:0] t;
      logic [pstcs_pkg::CNT_W-1:0] pre_len;
      logic [6:0] bdiv;
      logic bit_v;
      logic [1:0] pat;
      logic sel;
      logic txen;
      logic [1:0] fcnt;
      logic fq;
      logic fw;
      logic fullf;
      logic lbit;
      logic [$clog2(SEC_CYC)-1:0] sec_div;
      logic [pstcs_pkg::SEC_W-1:0] secs;
      logic full_due;
      logic [15:0] rdata;
      logic [15:0] rxsh;
      logic [7:0] nbits;
      logic [7:0] bitcnt;
   } pstcs_hst_s;

   pstcs_hst_s s_reg;
   pstcs_hst_s s_next;
   logic [DEPTH-1:0][15:0] fifo_reg;
   logic [DEPTH-1:0][15:0] fifo_next;
   logic bit_tick;
   logic [pstcs_pkg::CNT_W-1:0] slice_cyc;
   logic push;
   logic pop;
   logic full;

   always_comb begin
      s_next = s_reg;
      fifo_next = fifo_reg;
      bit_tick = (s_reg.bdiv == 7'(pstcs_pkg::BIT_CYC - 1));
      s_next.bdiv = bit_tick ? '0 : s_reg.bdiv + 1'b1;
      // Select falls only once the far end has surely locked
      slice_cyc = s_reg.ctrl[pstcs_pkg::CTRL_SHORT]
         ? 16'(pstcs_pkg::SLICE_SHORT_CYC + pstcs_pkg::SEL_GUARD_CYC)
         : 16'(pstcs_pkg::SLICE_LONG_CYC + pstcs_pkg::SEL_GUARD_CYC);
      full = (s_reg.fcnt == 2'(DEPTH));
      push = WR_I && (ADDR_I == pstcs_pkg::ADR_TXDATA) && !full;
      pop = 1'b0;
      s_next.sec_div = (s_reg.sec_div == ($clog2(SEC_CYC))'(SEC_CYC - 1))
         ? '0 : s_reg.sec_div + 1'b1;
      if (s_reg.sec_div == '0) begin
         s_next.secs = s_reg.secs + 1'b1;
         if (s_reg.secs == 8'(pstcs_pkg::FULL_CAL_S - 1)) begin
            s_next.full_due = 1'b1; // [RULE_09]
            s_next.secs = '0;
         end
      end
      if (WR_I && ADDR_I == pstcs_pkg::ADR_CTRL) begin
         s_next.ctrl = WDATA_I[4:0];
      end
      unique case (s_reg.st)
         pstcs_pkg::HST_IDLE: begin
            s_next.txen = 1'b0;
            s_next.sel = 1'b1;
            if (s_reg.ctrl[pstcs_pkg::CTRL_START] && s_reg.fcnt != '0) begin
               s_next.ctrl[pstcs_pkg::CTRL_START] = 1'b0;
               s_next.st = pstcs_pkg::HST_PRE;
               s_next.t = '0;
               s_next.txen = 1'b1;
               // Full-length preamble also when a periodic recalibration is due
               s_next.pre_len = (s_reg.ctrl[pstcs_pkg::CTRL_SHORT] && !s_reg.full_due)
                  ? 16'(pstcs_pkg::TX_PRE_SHORT_CYC) // [RULE_06]
                  : 16'(pstcs_pkg::TX_PRE_LONG_CYC); // [RULE_01] [RULE_09]
               s_next.fullf = s_reg.full_due;
               s_next.full_due = 1'b0;
               s_next.pat = 2'h0;
            end
         end
         pstcs_pkg::HST_PRE, pstcs_pkg::HST_ALT: begin
            s_next.t = s_reg.t + 1'b1; // [RULE_13]
            if (s_reg.t >= slice_cyc) begin
               s_next.sel = 1'b0; // [RULE_03] [RULE_08]
               if (s_reg.ctrl[pstcs_pkg::CTRL_ALT1100]) begin
                  s_next.st = pstcs_pkg::HST_ALT; // [RULE_10]
               end
            end
            if (bit_tick) begin
               s_next.pat = s_reg.pat + 1'b1;
            end
            if (s_reg.t >= s_reg.pre_len - 1'b1 && bit_tick) begin
               s_next.st = pstcs_pkg::HST_DATA; // [RULE_01]
               s_next.bitcnt = '0;
            end
         end
         pstcs_pkg::HST_DATA: begin
            if (bit_tick && LNK.line_ready) begin
               s_next.bitcnt = s_reg.bitcnt + 1'b1;
               if (s_reg.bitcnt == 8'hF) begin
                  pop = 1'b1;
                  s_next.st = pstcs_pkg::HST_IDLE;
               end
            end
         end
         default: s_next.st = pstcs_pkg::HST_IDLE;
      endcase
      s_next.bit_v = (s_reg.st != pstcs_pkg::HST_IDLE) && bit_tick;
      // Bit is registered with its strobe, so the last data bit is not lost
      if (bit_tick) begin
         if (s_reg.st == pstcs_pkg::HST_DATA) begin
            s_next.lbit = fifo_reg[s_reg.fq][~s_reg.bitcnt[3:0]];
         end else if (s_reg.st == pstcs_pkg::HST_ALT) begin
            s_next.lbit = s_reg.pat[1]; // [RULE_10]
         end else begin
            s_next.lbit = s_reg.pat[0];
         end
      end
      if (push) begin
         fifo_next[s_reg.fw] = WDATA_I;
         s_next.fw = s_reg.fw + 1'b1;
      end
      if (pop) begin
         s_next.fq = s_reg.fq + 1'b1;
      end
      s_next.fcnt = s_reg.fcnt + 2'(push) - 2'(pop);
      if (LNK.rx_bit_valid) begin
         s_next.rxsh = {s_reg.rxsh[14:0], LNK.rx_bit};
      end
      unique case (1'b1)
         RD_I && ADDR_I == pstcs_pkg::ADR_CTRL: s_next.rdata = {11'h000, s_reg.ctrl};
         RD_I && ADDR_I == pstcs_pkg::ADR_RXDATA: s_next.rdata = s_reg.rxsh;
         RD_I && ADDR_I == pstcs_pkg::ADR_STATUS:
            s_next.rdata = {8'h00, s_reg.full_due, full, s_reg.fcnt,
                            LNK.slice_locked, s_reg.sel, s_reg.st[1:0]};
         default: s_next.rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         s_reg <= '0;
         fifo_reg <= '0;
      end else begin
         s_reg <= s_next;
         fifo_reg <= fifo_next;
      end
   end

   assign RDATA_O = s_reg.rdata;
   assign LNK.chip_enable = 1'b1;
   assign LNK.receive_on = s_reg.txen;
   assign LNK.slicer_tc_select = s_reg.sel;
   assign LNK.slicer_tc_mode = s_reg.ctrl[pstcs_pkg::CTRL_SHORT] ? pstcs_pkg::TC_MODE_3US
                                                                 : pstcs_pkg::TC_MODE_6US;
   assign LNK.skip_vco_recal = s_reg.ctrl[pstcs_pkg::CTRL_SKIPV] & ~s_reg.fullf; // [RULE_09]
   assign LNK.clock_recovery_enable = s_reg.ctrl[pstcs_pkg::CTRL_CDR];
   assign LNK.line_valid = s_reg.bit_v;
   assign LNK.line_bit = s_reg.lbit;
endmodule : pstcs_host

// ===== include/pstcs_pkg.sv
// Shared constants and types for the preamble and slicer time-constant sequencer
package pstcs_pkg;

   // ---------------------------------------------------------------
   // Clock
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 100;

   // ---------------------------------------------------------------
   // Preamble and slicer timing, in microseconds
   // ---------------------------------------------------------------
   localparam int TX_PRE_LONG_US = 50;
   localparam int TX_PRE_SHORT_US = 25;
   localparam int SLICE_LONG_US = 20;
   localparam int SLICE_SHORT_US = 10;
   localparam int CDR_ACQ_US = 100;
   localparam int CAL_US = 2;

   // Least times round up
   localparam int TX_PRE_LONG_CYC = TX_PRE_LONG_US * CLK_MHZ;
   localparam int TX_PRE_SHORT_CYC = TX_PRE_SHORT_US * CLK_MHZ;
   localparam int SLICE_LONG_CYC = SLICE_LONG_US * CLK_MHZ;
   localparam int SLICE_SHORT_CYC = SLICE_SHORT_US * CLK_MHZ;
   localparam int CDR_ACQ_CYC = CDR_ACQ_US * CLK_MHZ;
   localparam int CAL_CYC = CAL_US * CLK_MHZ;
   // Far end counts pattern only after its calibration; select waits for that plus slack
   localparam int SEL_GUARD_CYC = CAL_CYC + 3 * 65;

   // Slicer time-constant modes served by the select pin
   localparam logic [2:0] TC_MODE_6US = 3'h4;
   localparam logic [2:0] TC_MODE_3US = 3'h5;

   // Bit period on the link, in clock cycles
   localparam int BIT_CYC = 65;

   // Full-calibration frame interval: three minutes
   localparam int FULL_CAL_S = 180;

   localparam int CNT_W = 16;
   localparam int SEC_W = 8;

   // ---------------------------------------------------------------
   // Software register map of the controller
   // ---------------------------------------------------------------
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_TXDATA = 4'h1;
   localparam logic [3:0] ADR_RXDATA = 4'h2;
   localparam logic [3:0] ADR_STATUS = 4'h3;

   localparam int CTRL_START = 0;
   localparam int CTRL_SHORT = 1;
   localparam int CTRL_CDR = 2;
   localparam int CTRL_SKIPV = 3;
   localparam int CTRL_ALT1100 = 4;

   typedef enum logic [2:0] {
      DEV_OFF = 3'h0,
      DEV_CAL = 3'h1,
      DEV_HUNT = 3'h2,
      DEV_SLICE = 3'h3
   } pstcs_dev_e;

   typedef enum logic [2:0] {
      HST_IDLE = 3'h0,
      HST_PRE = 3'h1,
      HST_ALT = 3'h2,
      HST_DATA = 3'h3
   } pstcs_hst_e;

endpackage : pstcs_pkg

// ===== include/pstcs_if.sv
// Link between the baseband controller and the transceiver slicer logic
interface pstcs_if;
   logic chip_enable;
   logic receive_on;
   logic slicer_tc_select;
   logic [2:0] slicer_tc_mode;
   logic skip_vco_recal;
   logic clock_recovery_enable;
   logic line_bit;
   logic line_valid;
   logic line_ready;
   logic rx_bit;
   logic rx_bit_valid;
   logic recovered_rx_clock;
   logic slice_locked;

   modport host (
      output chip_enable, receive_on, slicer_tc_select, slicer_tc_mode,
      output skip_vco_recal, clock_recovery_enable, line_bit, line_valid,
      input line_ready, rx_bit, rx_bit_valid, recovered_rx_clock, slice_locked
   );

   modport device (
      input chip_enable, receive_on, slicer_tc_select, slicer_tc_mode,
      input skip_vco_recal, clock_recovery_enable, line_bit, line_valid,
      output line_ready, rx_bit, rx_bit_valid, recovered_rx_clock, slice_locked
   );
endinterface : pstcs_if

// ===== logic/pstcs_device.sv
// Transceiver end: calibration, slice-point acquisition, clock recovery
module pstcs_device (
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RESETN_I,
   // Link
   pstcs_if.device LNK,
   // Status to user side
   output logic CAL_VCO_O,
   output logic CAL_IF_O,
   output logic TC_FAST_O
);
   typedef struct packed {
      pstcs_pkg::pstcs_dev_e st;
      logic [pstcs_pkg::CNT_W-1:0] cnt;
      logic [pstcs_pkg::CNT_W-1:0] acq;
      logic last_bit;
      logic locked;
      logic clk_ok;
      logic rclk;
      logic rco;
      logic [6:0] bdiv;
      logic vco;
      logic ifc;
      logic fast;
      logic rbit;
      logic rval;
   } pstcs_dev_s;

   pstcs_dev_s s_reg;
   pstcs_dev_s s_next;
   logic tc_ok;

   always_comb begin
      s_next = s_reg;
      s_next.rval = 1'b0;
      tc_ok = (LNK.slicer_tc_mode == pstcs_pkg::TC_MODE_6US) ||
              (LNK.slicer_tc_mode == pstcs_pkg::TC_MODE_3US);
      // Low select means the long constant in both modes
      s_next.fast = tc_ok & LNK.slicer_tc_select; // [RULE_04] [RULE_05]
      unique case (s_reg.st)
         pstcs_pkg::DEV_OFF: begin
            s_next.locked = 1'b0;
            s_next.clk_ok = 1'b0;
            if (LNK.chip_enable && LNK.receive_on) begin
               s_next.st = pstcs_pkg::DEV_CAL; // [RULE_12]
               s_next.cnt = '0;
               s_next.vco = ~LNK.skip_vco_recal; // [RULE_11]
               s_next.ifc = 1'b1;
            end
         end
         pstcs_pkg::DEV_CAL: begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt == 16'(pstcs_pkg::CAL_CYC - 1)) begin
               s_next.st = pstcs_pkg::DEV_HUNT; // [RULE_12]
               s_next.vco = 1'b0;
               s_next.ifc = 1'b0;
               s_next.cnt = '0;
            end
         end
         pstcs_pkg::DEV_HUNT: begin
            // Count alternating bits; any repeat restarts the acquisition
            if (LNK.line_valid) begin
               if (LNK.line_bit != s_reg.last_bit) begin
                  s_next.cnt = s_reg.cnt + 16'(pstcs_pkg::BIT_CYC);
               end else begin
                  s_next.cnt = '0;
               end
               s_next.last_bit = LNK.line_bit;
            end
            if (s_reg.fast && s_reg.cnt >= (LNK.slicer_tc_mode == pstcs_pkg::TC_MODE_3US
                  ? 16'(pstcs_pkg::SLICE_SHORT_CYC) : 16'(pstcs_pkg::SLICE_LONG_CYC))) begin
               s_next.st = pstcs_pkg::DEV_SLICE; // [RULE_02]
               s_next.locked = 1'b1;
               s_next.acq = '0;
            end
         end
         pstcs_pkg::DEV_SLICE: begin
            if (LNK.clock_recovery_enable && !s_reg.clk_ok) begin
               s_next.acq = s_reg.acq + 1'b1;
               if (s_reg.acq == 16'(pstcs_pkg::CDR_ACQ_CYC - 1)) begin
                  s_next.clk_ok = 1'b1; // [RULE_07]
               end
            end
            if (LNK.line_valid) begin
               s_next.rbit = LNK.line_bit;
               s_next.rval = 1'b1;
            end
         end
         default: s_next.st = pstcs_pkg::DEV_OFF;
      endcase
      if (!LNK.chip_enable || !LNK.receive_on) begin
         s_next.st = pstcs_pkg::DEV_OFF;
         // Lock clears one cycle after the receive span ends
         s_next.locked = 1'b0; // [RULE_12]
         s_next.clk_ok = 1'b0;
      end
      // Free-running divided clock, gated out until acquisition closes
      s_next.bdiv = (s_reg.bdiv == 7'(pstcs_pkg::BIT_CYC - 1)) ? '0 : s_reg.bdiv + 1'b1;
      if (s_reg.bdiv == '0) begin
         s_next.rclk = ~s_reg.rclk;
      end
      s_next.rco = s_next.rclk & s_next.clk_ok; // [RULE_07]
   end

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign LNK.line_ready = 1'b1;
   assign LNK.rx_bit = s_reg.rbit;
   assign LNK.rx_bit_valid = s_reg.rval;
   assign LNK.recovered_rx_clock = s_reg.rco; // [RULE_07]
   assign LNK.slice_locked = s_reg.locked;
   assign CAL_VCO_O = s_reg.vco;
   assign CAL_IF_O = s_reg.ifc;
   assign TC_FAST_O = s_reg.fast;
endmodule : pstcs_device

// ===== testbench/pstcs_monitor.sv
// Link checker for the slicer time-constant sequencer
module pstcs_monitor (
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RESETN_I,
   // Link signals
   input wire logic chip_enable,
   input wire logic receive_on,
   input wire logic slicer_tc_select,
   input wire logic [2:0] slicer_tc_mode,
   input wire logic clock_recovery_enable,
   input wire logic line_valid,
   input wire logic slice_locked,
   input wire logic recovered_rx_clock
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] rx_cnt;
   logic [15:0] lk_cnt;
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESETN_I);
   // ---------------------------------------------------------------
   // Cycle counters, saturating so long runs never wrap
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rx_cnt <= 16'h0000;
         lk_cnt <= 16'h0000;
      end else begin
         rx_cnt <= !receive_on ? 16'h0000 : (&rx_cnt ? rx_cnt : rx_cnt + 16'h0001);
         lk_cnt <= !slice_locked ? 16'h0000 : (&lk_cnt ? lk_cnt : lk_cnt + 16'h0001);
      end
   end
   sequence s_rx_entry;
      $rose(receive_on) ##0 chip_enable;
   endsequence
   AST_SEL_START: assert property (s_rx_entry |-> ##[0:2] slicer_tc_select)
      else $error("select not high at receive entry");
   AST_TC_MODE: assert property (receive_on && $past(receive_on) |->
      slicer_tc_mode inside {3'h4, 3'h5})
      else $error("unexpected slicer mode");
   // Calibration plus pattern span; the bit that completes the span counts whole
   AST_LOCK_EARLY: assert property ($rose(slice_locked) |->
      rx_cnt >= ((slicer_tc_mode == 3'h5) ? 16'h046E : 16'h0856))
      else $error("slice lock too early");
   AST_LOCK_LATE: assert property (rx_cnt == 16'h0C80 |-> slice_locked)
      else $error("slice lock missing");
   AST_SEL_EARLY: assert property ($fell(slicer_tc_select) && receive_on |->
      rx_cnt >= ((slicer_tc_mode == 3'h5) ? 16'h03E7 : 16'h07CF))
      else $error("select dropped too early");
   AST_SEL_LATE: assert property (rx_cnt == 16'h0FA0 |-> !slicer_tc_select)
      else $error("select still high");
   AST_RECOVERED_RX_CLOCK: assert property ($rose(recovered_rx_clock) |->
      clock_recovery_enable && lk_cnt >= 16'h26AC)
      else $error("recovered clock too early");
   AST_LINE_GAP: assert property ($rose(line_valid) |=> !line_valid [*8])
      else $error("line bits too close");
   AST_LOCK_DROP: assert property ($fell(receive_on) |=> !slice_locked)
      else $error("lock held after receive end");
endmodule : pstcs_monitor

// ===== testbench/pstcs_tb.sv
// Self-checking bench joining controller and transceiver ends
module pstcs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic cal_vco;
   logic cal_if;
   logic tc_fast;
   int mismatches = 0;
   int compares = 0;
   pstcs_if lnk ();
   pstcs_host #(.SEC_CYC(100)) i_pstcs_host (.CLK_SYS_I(clk), .RESETN_I(resetn),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .LNK(lnk.host));
   pstcs_device i_pstcs_device (.CLK_SYS_I(clk), .RESETN_I(resetn), .LNK(lnk.device),
      .CAL_VCO_O(cal_vco), .CAL_IF_O(cal_if), .TC_FAST_O(tc_fast));
   pstcs_monitor i_mon (.CLK_SYS_I(clk), .RESETN_I(resetn), .chip_enable(lnk.chip_enable),
      .receive_on(lnk.receive_on), .slicer_tc_select(lnk.slicer_tc_select),
      .slicer_tc_mode(lnk.slicer_tc_mode), .clock_recovery_enable(lnk.clock_recovery_enable),
      .line_valid(lnk.line_valid), .slice_locked(lnk.slice_locked),
      .recovered_rx_clock(lnk.recovered_rx_clock));
   always #5 clk = ~clk;
   // ---------------------------------------------------------------
   // Bus and compare helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   // Watches one whole frame; lock is judged only inside the receive span
   task automatic run_frame(input logic [15:0] ctrl, input logic [15:0] word,
      input logic [2:0] mode, input logic vco);
      int n;
      logic saw_vco;
      logic saw_if;
      logic saw_lock;
      logic saw_fast;
      logic [15:0] v;
      saw_vco = 1'b0;
      saw_if = 1'b0;
      saw_lock = 1'b0;
      saw_fast = 1'b0;
      wr_reg(pstcs_pkg::ADR_TXDATA, word);
      wr_reg(pstcs_pkg::ADR_CTRL, ctrl);
      n = 0;
      while (lnk.receive_on !== 1'b1 && n < 50) begin
         @(posedge clk);
         #1 n++;
      end
      chk(16'(lnk.receive_on), 16'h0001);
      @(posedge clk);
      #1 chk(16'(lnk.slicer_tc_mode), 16'(mode));
      n = 0;
      while (lnk.receive_on === 1'b1 && n < 20000) begin
         @(posedge clk);
         #1 n++;
         saw_vco |= cal_vco;
         saw_if |= cal_if;
         if (lnk.slicer_tc_select === 1'b1) saw_fast |= tc_fast;
         if (lnk.slice_locked === 1'b1 && !saw_lock) begin
            saw_lock = 1'b1;
            chk(16'(cal_if), 16'h0000);
         end
      end
      chk(16'(saw_vco), 16'(vco));
      chk(16'(saw_if), 16'h0001);
      chk(16'(saw_lock), 16'h0001);
      chk(16'(saw_fast), 16'h0001);
      rd_reg(pstcs_pkg::ADR_RXDATA, v);
      chk(v, word);
      wr_reg(pstcs_pkg::ADR_CTRL, 16'h0000);
   endtask : run_frame
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic test_reset();
      logic [15:0] v;
      chk(16'(lnk.slice_locked), 16'h0000);
      rd_reg(4'hF, v);
      chk(v, 16'h0000);
   endtask : test_reset
   task automatic test_long();
      run_frame(16'h0001, 16'hA5C3, pstcs_pkg::TC_MODE_6US, 1'b1);
   endtask : test_long
   task automatic test_short();
      run_frame(16'h000B, 16'h3C5A, pstcs_pkg::TC_MODE_3US, 1'b0);
   endtask : test_short
   task automatic test_cdr();
      run_frame(16'h0015, 16'hF00D, pstcs_pkg::TC_MODE_6US, 1'b1);
   endtask : test_cdr
   // Third word is refused while two wait; strobes back to back
   task automatic test_fifo();
      logic [15:0] v;
      @(posedge clk);
      addr <= pstcs_pkg::ADR_TXDATA;
      wdata <= 16'h0001;
      wr <= 1'b1;
      @(posedge clk);
      wdata <= 16'h0002;
      @(posedge clk);
      wdata <= 16'h0003;
      @(posedge clk);
      wr <= 1'b0;
      rd_reg(pstcs_pkg::ADR_STATUS, v);
      chk(16'(v[6]), 16'h0001);
   endtask : test_fifo
   task automatic print_verdict();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      test_reset();
      test_long();
      test_short();
      test_cdr();
      test_fifo();
      print_verdict();
   end
   // Three frames need well under 80k cycles
   initial begin
      #800000;
      mismatches++;
      print_verdict();
   end
endmodule : pstcs_tb
